// ===== verilog/hts_pkg.sv
// Constants, register map and types of the handler trigger sequencer
package hts_pkg;
    localparam int unsigned CLK_HZ          = 10_000_000;
    localparam int unsigned TICK_US         = 100;
    localparam int unsigned TICK_CYC        = (CLK_HZ / 1_000_000) * TICK_US;
    localparam int unsigned TRIG_MIN_NS     = 2000;
    localparam int unsigned TRIG_MIN_CYC    =
        (TRIG_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned SETTLE_FIXED_MS = 300;
    localparam int unsigned ACQ_BASE_US     = 6900;
    localparam int unsigned ACQ_STEP_US     = 3900;
    localparam int unsigned RDC_US          = 2000;
    localparam int unsigned RDC_OC_US       = 2000;
    localparam int unsigned DELAY_MAX_MS    = 1000;

    localparam logic [15:0] SETTLE_FIXED_TK = 16'(SETTLE_FIXED_MS * 1000 / TICK_US);
    localparam logic [15:0] ACQ_BASE_TK     = 16'(ACQ_BASE_US / TICK_US);
    localparam logic [15:0] ACQ_STEP_TK     = 16'(ACQ_STEP_US / TICK_US);
    localparam logic [15:0] RDC_TK          = 16'(RDC_US / TICK_US);
    localparam logic [15:0] RDC_OC_TK       = 16'(RDC_OC_US / TICK_US);
    localparam logic [15:0] DELAY_MAX_TK    = 16'(DELAY_MAX_MS * 1000 / TICK_US);

    localparam logic signed [15:0] LVL_THR_HI = -16'sd1295;
    localparam logic signed [15:0] LVL_THR_LO = -16'sd2295;

    localparam logic [7:0] OFS_CTRL        = 8'h00;
    localparam logic [7:0] OFS_AVG         = 8'h04;
    localparam logic [7:0] OFS_TRIG_DELAY  = 8'h08;
    localparam logic [7:0] OFS_POINT_DELAY = 8'h0C;
    localparam logic [7:0] OFS_LEVEL       = 8'h10;
    localparam logic [7:0] OFS_FREQ_SETTLE = 8'h14;
    localparam logic [7:0] OFS_STATUS      = 8'h18;
    localparam logic [7:0] OFS_INT_STS     = 8'h1C;
    localparam logic [7:0] OFS_INT_MASK    = 8'h20;
    localparam logic [7:0] OFS_CYCLES      = 8'h24;
    localparam logic [7:0] OFS_CMD         = 8'h28;

    localparam int unsigned CTRL_EN_BIT  = 0;
    localparam int unsigned CTRL_RDC_BIT = 1;
    localparam int unsigned CTRL_OC_BIT  = 2;
    localparam logic [2:0]  CTRL_RST     = 3'h1;
    localparam logic [7:0]  AVG_RST      = 8'h01;
    localparam int unsigned IRQ_DONE_BIT = 0;
    localparam int unsigned IRQ_MISS_BIT = 1;
    localparam int unsigned IRQ_XING_BIT = 2;
    localparam int unsigned IRQ_W        = 3;

    typedef enum logic [5:0] {
        ST_IDLE   = 6'b000001,
        ST_SETTLE = 6'b000010,
        ST_TDLY   = 6'b000100,
        ST_PDLY   = 6'b001000,
        ST_RDC    = 6'b010000,
        ST_ACQ    = 6'b100000
    } hts_state_t;
endpackage : hts_pkg

// ===== verilog/hts_interval_timer.sv
// Interval timer counting 0.1 ms ticks from a clock divider
`timescale 1ns/1ns
module hts_interval_timer #(
    parameter int unsigned TICK_CYC_P = 1000,
    parameter int unsigned W          = 16
) (
    input  wire logic         ref_clk,
    input  wire logic         rst,
    input  wire logic         start,
    input  wire logic [W-1:0] load,
    input  wire logic         pause,
    output logic              done
);
    localparam int unsigned PW = $clog2(TICK_CYC_P);

    logic [PW-1:0] presc_r;
    logic [W-1:0]  cnt_r;
    logic          run_r;
    logic          done_r;

    assign done = done_r;

    // Pause freezes the divider too, so a stall never shortens an interval
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            presc_r <= '0;
            cnt_r   <= '0;
            run_r   <= 1'b0;
            done_r  <= 1'b0;
        end else begin
            done_r <= 1'b0;
            if (start) begin
                presc_r <= '0;
                cnt_r   <= load;
                run_r   <= 1'b1;
            end else if (run_r && !pause) begin
                if (cnt_r == '0) begin
                    run_r  <= 1'b0;
                    done_r <= 1'b1;
                end else if (presc_r == PW'(TICK_CYC_P - 1)) begin
                    presc_r <= '0;
                    cnt_r   <= cnt_r - 1'b1;
                end else begin
                    presc_r <= presc_r + 1'b1;
                end
            end
        end
    end
endmodule : hts_interval_timer

// ===== verilog/hts_sequencer.sv
// Handler trigger measurement sequencer with APB registers
`timescale 1ns/1ns
module hts_sequencer
    import hts_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        ext_trigger,
    input  wire logic        hold_off,
    output logic             ready_for_trigger,
    output logic             analog_done,
    output logic             cycle_finished_flag,
    output logic             irq
);
    logic [31:0]          prdata_r;
    logic                 pready_r;
    logic                 pslverr_r;
    logic [2:0]           ctrl_r;
    logic [7:0]           avg_r;
    logic [15:0]          tdly_r;
    logic [15:0]          pdly_r;
    logic signed [15:0]   level_r;
    logic signed [15:0]   prev_level_r;
    logic [15:0]          freq_settle_r;
    logic [IRQ_W-1:0]     int_sts_r;
    logic [IRQ_W-1:0]     int_mask_r;
    logic [15:0]          cycles_r;
    logic                 sw_trig_r;
    logic                 irq_r;
    logic [2:0]           trig_sync_r;
    logic                 trig_lvl_r;
    logic [7:0]           trig_hi_cnt_r;
    logic                 hw_trig_r;
    hts_state_t           state_r;
    logic                 tmr_start_r;
    logic [15:0]          tmr_load_r;
    logic                 tmr_done;
    logic                 ready_r;
    logic                 index_r;
    logic                 eom_r;
    logic                 xing_r;
    logic                 miss_evt;
    logic                 done_evt;
    logic                 xing_evt;
    logic                 trig_any;
    logic                 acc_wr;
    logic                 setup_ph;
    logic [IRQ_W-1:0]     int_set;
    logic [IRQ_W-1:0]     int_clr;

    function automatic logic crossed(input logic signed [15:0] a,
                                     input logic signed [15:0] b);
        crossed = ((a > LVL_THR_HI) != (b > LVL_THR_HI)) ||
                  ((a > LVL_THR_LO) != (b > LVL_THR_LO));
    endfunction : crossed

    function automatic logic [15:0] clamp_delay(input logic [31:0] v);
        clamp_delay = (v > 32'(DELAY_MAX_TK)) ? DELAY_MAX_TK : v[15:0];
    endfunction : clamp_delay

    function automatic logic [15:0] acq_ticks(input logic [7:0] avg);
        logic [7:0] steps;
        steps = (avg == 8'h00) ? 8'h00 : avg - 8'h01;
        acq_ticks = 16'(ACQ_BASE_TK + 16'(ACQ_STEP_TK * steps));
    endfunction : acq_ticks

    function automatic logic [15:0] rdc_ticks(input logic oc);
        rdc_ticks = oc ? 16'(RDC_TK + RDC_OC_TK) : RDC_TK;
    endfunction : rdc_ticks

    assign prdata              = prdata_r;
    assign pready              = pready_r;
    assign pslverr             = pslverr_r;
    assign ready_for_trigger   = ready_r;
    assign analog_done         = index_r;
    assign cycle_finished_flag = eom_r;
    assign irq                 = irq_r;

    assign setup_ph = psel && !penable;
    assign acc_wr   = psel && penable && pready_r && pwrite;
    assign trig_any = hw_trig_r || sw_trig_r;

    hts_interval_timer #(
        .TICK_CYC_P (TICK_CYC),
        .W          (16)
    ) u_timer (
        .ref_clk (ref_clk),
        .rst     (rst),
        .start   (tmr_start_r),
        .load    (tmr_load_r),
        .pause   (hold_off),
        .done    (tmr_done)
    );

    // APB: no wait states, answer registered so outputs come from flops
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else if (setup_ph) begin
            pready_r  <= 1'b1;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
            if (paddr == OFS_CTRL) begin
                prdata_r <= {29'h0, ctrl_r};
            end else if (paddr == OFS_AVG) begin
                prdata_r <= {24'h0, avg_r};
            end else if (paddr == OFS_TRIG_DELAY) begin
                prdata_r <= {16'h0, tdly_r};
            end else if (paddr == OFS_POINT_DELAY) begin
                prdata_r <= {16'h0, pdly_r};
            end else if (paddr == OFS_LEVEL) begin
                prdata_r <= {16'h0, level_r};
            end else if (paddr == OFS_FREQ_SETTLE) begin
                prdata_r <= {16'h0, freq_settle_r};
            end else if (paddr == OFS_STATUS) begin
                prdata_r <= {16'h0, state_r, 6'h0, xing_r, ready_r, eom_r, index_r};
            end else if (paddr == OFS_INT_STS) begin
                prdata_r <= {29'h0, int_sts_r};
            end else if (paddr == OFS_INT_MASK) begin
                prdata_r <= {29'h0, int_mask_r};
            end else if (paddr == OFS_CYCLES) begin
                prdata_r <= {16'h0, cycles_r};
            end else if (paddr == OFS_CMD) begin
                prdata_r <= 32'h0000_0000;
            end else begin
                pslverr_r <= 1'b1;
            end
        end else begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end
    end

    // Configuration registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctrl_r        <= CTRL_RST;
            avg_r         <= AVG_RST;
            tdly_r        <= 16'h0000;
            pdly_r        <= 16'h0000;
            level_r       <= 16'sh0000;
            freq_settle_r <= 16'h0000;
            int_mask_r    <= '0;
        end else if (acc_wr) begin
            if (paddr == OFS_CTRL) begin
                ctrl_r <= pwdata[2:0];
            end else if (paddr == OFS_AVG) begin
                avg_r <= pwdata[7:0];
            end else if (paddr == OFS_TRIG_DELAY) begin
                tdly_r <= clamp_delay(pwdata);
            end else if (paddr == OFS_POINT_DELAY) begin
                pdly_r <= clamp_delay(pwdata);
            end else if (paddr == OFS_LEVEL) begin
                level_r <= pwdata[15:0];
            end else if (paddr == OFS_FREQ_SETTLE) begin
                freq_settle_r <= pwdata[15:0];
            end else if (paddr == OFS_INT_MASK) begin
                int_mask_r <= pwdata[IRQ_W-1:0];
            end
        end
    end

    // Software trigger is a one-cycle command strobe
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sw_trig_r <= 1'b0;
        end else begin
            sw_trig_r <= acc_wr && (paddr == OFS_CMD) && pwdata[0];
        end
    end

    // Trigger pin: three flops, level moves only when stages two and three agree
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            trig_sync_r <= 3'h0;
            trig_lvl_r  <= 1'b0;
        end else begin
            trig_sync_r <= {trig_sync_r[1:0], ext_trigger};
            if (trig_sync_r[1] == trig_sync_r[2]) begin
                trig_lvl_r <= trig_sync_r[2];
            end
        end
    end

    // Pulses shorter than the minimum width are rejected as glitches
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            trig_hi_cnt_r <= 8'h00;
            hw_trig_r     <= 1'b0;
        end else begin
            hw_trig_r <= 1'b0;
            if (!trig_lvl_r) begin
                trig_hi_cnt_r <= 8'h00;
            end else if (trig_hi_cnt_r != 8'(TRIG_MIN_CYC)) begin
                trig_hi_cnt_r <= trig_hi_cnt_r + 8'h01;
                if (trig_hi_cnt_r == 8'(TRIG_MIN_CYC - 1)) begin
                    hw_trig_r <= 1'b1;
                end
            end
        end
    end

    assign miss_evt = trig_any && ((state_r != ST_IDLE) || !ctrl_r[CTRL_EN_BIT]);
    assign done_evt = (state_r == ST_ACQ) && tmr_done;
    assign xing_evt = (state_r == ST_IDLE) && trig_any && ctrl_r[CTRL_EN_BIT] &&
                      crossed(prev_level_r, level_r);

    // Measurement cycle; each interval ends only on the timer, never on a bound
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_r      <= ST_IDLE;
            tmr_start_r  <= 1'b0;
            tmr_load_r   <= 16'h0000;
            prev_level_r <= 16'sh0000;
            xing_r       <= 1'b0;
            ready_r      <= 1'b1;
            index_r      <= 1'b1;
            eom_r        <= 1'b1;
            cycles_r     <= 16'h0000;
        end else begin
            tmr_start_r <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    if (trig_any && ctrl_r[CTRL_EN_BIT]) begin
                        ready_r      <= 1'b0;
                        index_r      <= 1'b0;
                        eom_r        <= 1'b0;
                        prev_level_r <= level_r;
                        xing_r       <= xing_evt;
                        tmr_start_r  <= 1'b1;
                        if (xing_evt) begin
                            tmr_load_r <= SETTLE_FIXED_TK;
                        end else begin
                            tmr_load_r <= freq_settle_r;
                        end
                        state_r <= ST_SETTLE;
                    end
                end
                ST_SETTLE: begin
                    if (tmr_done) begin
                        tmr_start_r <= 1'b1;
                        tmr_load_r  <= tdly_r;
                        state_r     <= ST_TDLY;
                    end
                end
                ST_TDLY: begin
                    if (tmr_done) begin
                        tmr_start_r <= 1'b1;
                        tmr_load_r  <= pdly_r;
                        state_r     <= ST_PDLY;
                    end
                end
                ST_PDLY: begin
                    if (tmr_done) begin
                        tmr_start_r <= 1'b1;
                        if (ctrl_r[CTRL_RDC_BIT]) begin
                            tmr_load_r <= rdc_ticks(ctrl_r[CTRL_OC_BIT]);
                            state_r    <= ST_RDC;
                        end else begin
                            tmr_load_r <= acq_ticks(avg_r);
                            state_r    <= ST_ACQ;
                        end
                    end
                end
                ST_RDC: begin
                    if (tmr_done) begin
                        tmr_start_r <= 1'b1;
                        tmr_load_r  <= acq_ticks(avg_r);
                        state_r     <= ST_ACQ;
                    end
                end
                ST_ACQ: begin
                    if (tmr_done) begin
                        index_r  <= 1'b1;
                        eom_r    <= 1'b1;
                        ready_r  <= 1'b1;
                        cycles_r <= cycles_r + 16'h0001;
                        state_r  <= ST_IDLE;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    assign int_set = {xing_evt, miss_evt, done_evt};
    assign int_clr = (acc_wr && (paddr == OFS_INT_STS)) ? pwdata[IRQ_W-1:0] : '0;

    // Sticky status, set beats a same-cycle write-one clear
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            int_sts_r <= '0;
            irq_r     <= 1'b0;
        end else begin
            int_sts_r <= (int_sts_r & ~int_clr) | int_set;
            irq_r     <= |(((int_sts_r & ~int_clr) | int_set) & int_mask_r);
        end
    end
endmodule : hts_sequencer

// ===== test/hts_handler_model.sv
// Component handler model driving the trigger pin
`timescale 1ns/1ns
module hts_handler_model #(
    parameter int unsigned HOLD_CYC = 25
) (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic go,
    input  wire logic ready_for_trigger,
    output logic      ext_trigger
);
    int unsigned cnt_r;

    // Pulse of HOLD_CYC cycles, above the 2 us minimum
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ext_trigger <= 1'b0;
            cnt_r       <= 0;
        end else if (cnt_r != 0) begin
            cnt_r       <= cnt_r - 1;
            ext_trigger <= (cnt_r != 1);
        end else if (go && ready_for_trigger) begin
            ext_trigger <= 1'b1;
            cnt_r       <= HOLD_CYC;
        end
    end
endmodule : hts_handler_model

// ===== test/hts_sequencer_asserts.sv
// Port-level assertions for the handler trigger sequencer
`timescale 1ns/1ns
module hts_sequencer_asserts
    import hts_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        hold_off,
    input wire logic        ready_for_trigger,
    input wire logic        analog_done,
    input wire logic        cycle_finished_flag
);
    localparam int unsigned MIN_BUSY = ACQ_BASE_TK * TICK_CYC;
    logic [31:0] busy_cnt_r;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // Busy length counter; too long for a repetition
    always_ff @(posedge ref_clk) begin
        if (rst || ready_for_trigger) begin
            busy_cnt_r <= 32'h0;
        end else begin
            busy_cnt_r <= busy_cnt_r + 32'h1;
        end
    end

    property p_pready_pulse;
        pready |=> !pready;
    endproperty
    a_pready_pulse: assert property (p_pready_pulse) else $error("pready longer than one cycle");
    property p_pready_after_setup;
        psel && !penable |=> pready;
    endproperty
    a_pready_after_setup: assert property (p_pready_after_setup) else $error("no answer to setup");
    property p_slverr_with_ready;
        pslverr |-> pready;
    endproperty
    a_slverr_with_ready: assert property (p_slverr_with_ready) else $error("stray pslverr");
    property p_err_map;
        pready && paddr[1:0] == 2'b00 |-> pslverr == (paddr > OFS_CMD);
    endproperty
    a_err_map: assert property (p_err_map) else $error("pslverr disagrees with map");
    property p_cmd_read_zero;
        pready && !pwrite && paddr == OFS_CMD |-> prdata == 32'h0;
    endproperty
    a_cmd_read_zero: assert property (p_cmd_read_zero) else $error("command reads nonzero");
    property p_flags_agree;
        ready_for_trigger == cycle_finished_flag && ready_for_trigger == analog_done;
    endproperty
    a_flags_agree: assert property (p_flags_agree) else $error("end flags disagree");
    property p_min_cycle;
        $rose(ready_for_trigger) |-> busy_cnt_r >= MIN_BUSY;
    endproperty
    a_min_cycle: assert property (p_min_cycle) else $error("cycle shorter than acquisition");
    property p_hold_freeze;
        hold_off [*3] ##0 !ready_for_trigger |=> !ready_for_trigger;
    endproperty
    a_hold_freeze: assert property (p_hold_freeze) else $error("cycle ended while held");
endmodule : hts_sequencer_asserts

bind hts_sequencer hts_sequencer_asserts i_hts_sequencer_asserts (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hold_off(hold_off), .ready_for_trigger(ready_for_trigger),
    .analog_done(analog_done), .cycle_finished_flag(cycle_finished_flag)
);

// ===== test/hts_sequencer_tb.sv
// Self-checking bench for the handler trigger sequencer
`timescale 1ns/1ns
module hts_sequencer_tb
    import hts_pkg::*;
;
    logic        ref_clk;
    logic        rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        ext_trigger;
    logic        hold_off;
    logic        go;
    logic        ready_for_trigger;
    logic        analog_done;
    logic        cycle_finished_flag;
    logic        irq;
    int unsigned bad_count;
    int unsigned tests_run;
    int unsigned n;
    logic [31:0] rd;
    logic        err;

`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin bad_count++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, exp, got); end end

    hts_sequencer i_hts_sequencer (
        .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_trigger(ext_trigger), .hold_off(hold_off),
        .ready_for_trigger(ready_for_trigger), .analog_done(analog_done),
        .cycle_finished_flag(cycle_finished_flag), .irq(irq)
    );
    hts_handler_model i_hts_handler_model (
        .ref_clk(ref_clk), .rst(rst), .go(go),
        .ready_for_trigger(ready_for_trigger), .ext_trigger(ext_trigger)
    );

    task automatic tally_and_finish();
        $display("Checks run %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish

    // One idle edge first, so a release and a new setup never share a time step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rdv, output logic erv);
        int unsigned k;
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            bad_count++;
            tally_and_finish();
        end
        rdv = prdata;
        erv = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rd, err);
    endtask : wr

    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] exp);
        apb(1'b0, a, 32'h0, rd, err);
        `CHK(nm, exp, rd & m)
    endtask : rchk

    // Holds the cycle frozen for 3000 cycles partway through
    task automatic wait_rdy(input logic lvl, input int unsigned lim, output int unsigned c);
        c = 0;
        while (ready_for_trigger !== lvl && c < lim) begin
            @(posedge ref_clk);
            c++;
            hold_off <= (c >= 30000 && c < 33000);
        end
        if (c >= lim) begin
            bad_count++;
            tally_and_finish();
        end
    endtask : wait_rdy

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    initial begin
        bad_count = 0;
        tests_run = 0;
        rst       = 1'b1;
        psel      = 1'b0;
        penable   = 1'b0;
        pwrite    = 1'b0;
        paddr     = 8'h00;
        pwdata    = 32'h0;
        hold_off  = 1'b0;
        go        = 1'b0;
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        rchk("ctrl_rst", OFS_CTRL, 32'hFFFF_FFFF, 32'(CTRL_RST));
        rchk("avg_rst", OFS_AVG, 32'hFFFF_FFFF, 32'(AVG_RST));
        rchk("mask_rst", OFS_INT_MASK, 32'hFFFF_FFFF, 32'h0);
        rchk("cmd_read", OFS_CMD, 32'hFFFF_FFFF, 32'h0);
        apb(1'b0, 8'h40, 32'h0, rd, err);
        `CHK("unmapped_err", 1'b1, err)
        `CHK("ready_rst", 1'b1, ready_for_trigger)
        // Level -13.00 dBm against 0: crosses the upper threshold
        wr(OFS_INT_MASK, 32'h7);
        wr(OFS_LEVEL, 32'h0000_FAEC);
        wr(OFS_CMD, 32'h1);
        rchk("xing_state", OFS_STATUS, 32'h0000_FC08, 32'h0000_0808);
        rchk("xing_flag", OFS_INT_STS, 32'h4, 32'h4);
        `CHK("xing_irq", 1'b1, irq)
        repeat (2000) @(posedge ref_clk);
        rchk("xing_long", OFS_STATUS, 32'h0000_FC00, 32'h0000_0800);
        // Abort the 300 ms settle rather than sit through it
        rst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        wr(OFS_LEVEL, 32'h0000_FC18);
        wr(OFS_CTRL, 32'h3);
        wr(OFS_FREQ_SETTLE, 32'h1);
        wr(OFS_TRIG_DELAY, 32'h0001_0000);
        rchk("tdly_clamp", OFS_TRIG_DELAY, 32'hFFFF_FFFF, 32'(DELAY_MAX_TK));
        wr(OFS_TRIG_DELAY, 32'h2);
        wr(OFS_POINT_DELAY, 32'h1);
        wr(OFS_INT_MASK, 32'h1);
        @(posedge ref_clk);
        go <= 1'b1;
        wait_rdy(1'b0, 200, n);
        go <= 1'b0;
        rchk("busy_flags", OFS_STATUS, 32'h7, 32'h0);
        wr(OFS_CMD, 32'h1);
        rchk("missed", OFS_INT_STS, 32'h7, 32'h2);
        `CHK("missed_masked", 1'b0, irq)
        wr(OFS_INT_STS, 32'h2);
        wait_rdy(1'b1, 120000, n);
        `CHK("cycle_len", 1'b1, (n >= 95950 && n <= 96100))
        `CHK("done_irq", 1'b1, irq)
        rchk("idle_status", OFS_STATUS, 32'h0000_FC07, 32'h0000_0407);
        rchk("cycles", OFS_CYCLES, 32'hFFFF_FFFF, 32'h1);
        wr(OFS_INT_STS, 32'h1);
        rchk("w1c", OFS_INT_STS, 32'h7, 32'h0);
        repeat (2) @(posedge ref_clk);
        `CHK("irq_clear", 1'b0, irq)
        tally_and_finish();
    end
endmodule : hts_sequencer_tb
